// >>> src/uchcfg_pkg.sv
// constants, register map and field layout of the serial channel configuration block
// How it works
// (RULE_01) stop field: 00 no stop, 01 one, 10 two stop bits; 11 prohibited
// (RULE_02) length field: 01 nine bits, 10 seven bits, 11 eight bits; 00 prohibited
// (RULE_03) divider bits 15..9 give bit clock = clock / (2 * value + 2)
// (RULE_04) software loads divider 1001101 for clock / 156, near 9600 bit/s
// (RULE_05) line level bit drives transmit line low at 0, high at 1
// (RULE_06) output enable bit lets the serial engine drive the transmit line
// (RULE_07) filter enable bit switches receive input noise filter on or bypasses it
// (RULE_08) writing 1 to clear bit 2 clears framing error flag
// (RULE_09) writing 1 to clear bit 1 clears parity error flag
// (RULE_10) writing 1 to clear bit 0 clears overrun error flag
// (RULE_11) mask bits for error, receive and transmit events block requests at 1
// (RULE_12) two priority bits per source pick level 0 highest to 3 lowest
// (RULE_13) direction bit 0 drives the pin as output, 1 makes it input
// (RULE_14) in output mode the latch bit value drives the pin
// (RULE_15) transmit/receive enable pair: off, receive, transmit, or both directions
// (RULE_16) parity field: none, zero without check, even, odd
// (RULE_17) software waits four clocks after receive enable before start trigger
// (RULE_18) with start source set, a falling receive edge starts reception
// (RULE_19) stop low sets framing, parity mismatch parity, unread data overrun
package uchcfg_pkg;
  // ----------------------------------------------------------------
  // bus and register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_COMM_CONFIG = 8'h00;
  localparam logic [7:0] OFS_DATA_DIVIDER = 8'h04;
  localparam logic [7:0] OFS_OUT_LEVEL = 8'h08;
  localparam logic [7:0] OFS_OUT_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_FILTER_EN = 8'h10;
  localparam logic [7:0] OFS_ERR_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_PRIO_BIT0 = 8'h1C;
  localparam logic [7:0] OFS_PRIO_BIT1 = 8'h20;
  localparam logic [7:0] OFS_PORT_LATCH = 8'h24;
  localparam logic [7:0] OFS_PORT_DIR = 8'h28;
  localparam logic [7:0] OFS_MODE = 8'h2C;
  localparam logic [7:0] OFS_START = 8'h30;
  localparam logic [7:0] OFS_CH_STATUS = 8'h34;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h38;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h3C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h40;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_TX_EN = 15;
  localparam int CFG_RX_EN = 14;
  localparam int CFG_ERR_IRQ = 10;
  localparam int CFG_PAR_LO = 8;
  localparam int CFG_ORDER = 7;
  localparam int CFG_STOP_LO = 4;
  localparam int CFG_LEN_LO = 0;
  localparam int DIV_LO = 9;
  localparam int CLR_FRAMING = 2;
  localparam int CLR_PARITY = 1;
  localparam int CLR_OVERRUN = 0;
  localparam int MODE_START_SRC = 8;
  localparam int START_CH1 = 1;
  localparam int ST_OVR = 0;
  localparam int ST_PAR = 1;
  localparam int ST_FRM = 2;
  localparam int ST_RX_FULL = 3;
  localparam int ST_RX_BUSY = 4;
  localparam int ST_TX_BUSY = 5;
  localparam int ST_ACTIVE = 6;
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_RX_ERR = 1;
  localparam int IRQ_TX_DONE = 2;
  localparam int NUM_SRC = 3;
  // mask and priority bit of each source, in source order
  localparam int SRC_POS [NUM_SRC] = '{4, 5, 3};
  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] STOP_NONE = 2'h0;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] LEN_9 = 2'h1;
  localparam logic [1:0] LEN_7 = 2'h2;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [15:0] RST_CFG = 16'h0000;
  localparam logic [6:0] RST_DIV = 7'h00;
  localparam logic [7:0] RST_MASK = 8'h38;
  localparam logic [7:0] RST_PRIO = 8'h38;
  localparam logic [7:0] RST_LEVEL = 8'h01;
  localparam logic [7:0] RST_PORT_DIR = 8'hFF;
  localparam int FRAME_W = 13;
endpackage : uchcfg_pkg

// >>> src/uchcfg_top.sv
// serial channel configuration block with receiver, transmitter and avalon slave
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module uchcfg_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [uchcfg_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [uchcfg_pkg::DATA_W-1:0] avs_writedata,
  output logic [uchcfg_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic [uchcfg_pkg::NUM_SRC-1:0] irq_req,
  output logic [2*uchcfg_pkg::NUM_SRC-1:0] irq_prio,
  input wire logic serial_rx_pin,
  output logic [7:0] port0_o,
  output logic [7:0] port0_oe
);
  import uchcfg_pkg::*;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PARITY = 5'b01000,
    RX_STOP = 5'b10000
  } uchcfg_rx_e;

  // ----------------------------------------------------------------
  // registers and internal state
  // ----------------------------------------------------------------
  logic [15:0] cfg_r;
  logic [6:0] div_r;
  logic [7:0] level_r, oen_r, filt_en_r, mask_r, prio0_r, prio1_r, latch_r, dir_r;
  logic start_src_r, active_r, sw_start_r, ack_r;
  logic [DATA_W-1:0] rd_mux, rdata_r;
  logic [2:0] irq_stat_r, irq_en_r;
  logic rx_s1_r, rx_s2_r, rx_s3_r, rx_f_r, rx_prev_r;
  uchcfg_rx_e rx_state_r;
  logic [7:0] rx_cnt_r;
  logic [3:0] rx_idx_r;
  logic [8:0] rx_shift_r, rx_data_r;
  logic rx_stop2_r, rx_end_r, rx_perr_r, rx_ferr_r;
  logic rx_full_r, fef_r, pef_r, ovf_r;
  logic [FRAME_W-1:0] tx_shift_r, tx_frame;
  logic [3:0] tx_left_r, tx_count;
  logic [7:0] tx_cnt_r;
  logic tx_busy_r, tx_done_r, irq_r;
  logic [NUM_SRC-1:0] irq_req_r, ev;
  logic [2*NUM_SRC-1:0] irq_prio_r;

  logic do_wr, do_rd, tx_en, rx_en, lsb_first, err_irq_en, fall_edge;
  logic [1:0] par_sel, stop_sel, len_sel;
  logic [3:0] len_bits, rx_pos;
  logic [7:0] period_m1, half_m1;

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  // (RULE_15) direction enables gate each engine
  assign tx_en = cfg_r[CFG_TX_EN];
  assign rx_en = cfg_r[CFG_RX_EN];
  assign err_irq_en = cfg_r[CFG_ERR_IRQ];
  assign par_sel = cfg_r[CFG_PAR_LO +: 2];
  assign lsb_first = cfg_r[CFG_ORDER];
  assign stop_sel = cfg_r[CFG_STOP_LO +: 2];
  assign len_sel = cfg_r[CFG_LEN_LO +: 2];
  // (RULE_02) prohibited length code falls back to eight bits
  assign len_bits = (len_sel == LEN_9) ? BITS_9 : (len_sel == LEN_7) ? BITS_7 : BITS_8;
  // (RULE_03) bit time is 2*div+2 clocks; half time for the start check
  assign period_m1 = {div_r, 1'b1};
  assign half_m1 = {1'b0, div_r};
  assign rx_pos = lsb_first ? rx_idx_r : len_bits - 4'h1 - rx_idx_r;
  assign fall_edge = rx_prev_r & ~rx_f_r;

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then the access completes
  // ----------------------------------------------------------------
  assign do_wr = avs_write & ack_r;
  assign do_rd = avs_read & ack_r;

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = '0;
    unique case (avs_address)
      OFS_COMM_CONFIG: rd_mux[15:0] = cfg_r;
      OFS_DATA_DIVIDER: rd_mux[15:0] = {div_r, rx_data_r};
      OFS_OUT_LEVEL: rd_mux[7:0] = level_r;
      OFS_OUT_ENABLE: rd_mux[7:0] = oen_r;
      OFS_FILTER_EN: rd_mux[7:0] = filt_en_r;
      OFS_IRQ_MASK: rd_mux[7:0] = mask_r;
      OFS_PRIO_BIT0: rd_mux[7:0] = prio0_r;
      OFS_PRIO_BIT1: rd_mux[7:0] = prio1_r;
      OFS_PORT_LATCH: rd_mux[7:0] = latch_r;
      OFS_PORT_DIR: rd_mux[7:0] = dir_r;
      OFS_MODE: rd_mux[MODE_START_SRC] = start_src_r;
      OFS_CH_STATUS: rd_mux[6:0] = {active_r, tx_busy_r, rx_state_r != RX_IDLE,
                                    rx_full_r, fef_r, pef_r, ovf_r};
      OFS_IRQ_STATUS: rd_mux[2:0] = irq_stat_r;
      OFS_IRQ_ENABLE: rd_mux[2:0] = irq_en_r;
      default: rd_mux = '0;
    endcase
  end

  // handshake: ack rises one cycle after the request, read data latched with it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else if (ce) begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (avs_read & ~ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = ~ack_r;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // plain read/write registers, written at the completing edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= RST_CFG;
      div_r <= RST_DIV;
      level_r <= RST_LEVEL;
      oen_r <= '0;
      filt_en_r <= '0;
      mask_r <= RST_MASK;
      prio0_r <= RST_PRIO;
      prio1_r <= RST_PRIO;
      latch_r <= '0;
      dir_r <= RST_PORT_DIR;
      start_src_r <= 1'b0;
      irq_en_r <= '0;
    end else if (ce && do_wr) begin
      unique case (avs_address)
        OFS_COMM_CONFIG: cfg_r <= avs_writedata[15:0];
        // (RULE_04) divider field loaded by software
        OFS_DATA_DIVIDER: div_r <= avs_writedata[DIV_LO +: 7];
        OFS_OUT_LEVEL: level_r <= avs_writedata[7:0];
        OFS_OUT_ENABLE: oen_r <= avs_writedata[7:0];
        OFS_FILTER_EN: filt_en_r <= avs_writedata[7:0];
        OFS_IRQ_MASK: mask_r <= avs_writedata[7:0];
        OFS_PRIO_BIT0: prio0_r <= avs_writedata[7:0];
        OFS_PRIO_BIT1: prio1_r <= avs_writedata[7:0];
        OFS_PORT_LATCH: latch_r <= avs_writedata[7:0];
        OFS_PORT_DIR: dir_r <= avs_writedata[7:0];
        OFS_MODE: start_src_r <= avs_writedata[MODE_START_SRC];
        OFS_IRQ_ENABLE: irq_en_r <= avs_writedata[2:0];
        default: ;
      endcase
    end
  end

  // channel start: trigger enters wait state, off mode (both enables 0) leaves it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= 1'b0;
      sw_start_r <= 1'b0;
    end else if (ce) begin
      sw_start_r <= do_wr && avs_address == OFS_START && avs_writedata[START_CH1];
      if (do_wr && avs_address == OFS_START && avs_writedata[START_CH1]) begin
        active_r <= 1'b1;
      end else if (!tx_en && !rx_en) begin
        active_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive input: synchroniser and noise filter
  // ----------------------------------------------------------------
  // only the second and third stages are looked at; the filter wants two equal samples
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_f_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else if (ce) begin
      rx_s1_r <= serial_rx_pin;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      rx_prev_r <= rx_f_r;
      // (RULE_07) filter on: glitches of one clock are dropped
      if (!filt_en_r[0] || rx_s2_r == rx_s3_r) begin
        rx_f_r <= rx_s2_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver state machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= '0;
      rx_idx_r <= '0;
      rx_shift_r <= '0;
      rx_stop2_r <= 1'b0;
      rx_end_r <= 1'b0;
      rx_perr_r <= 1'b0;
      rx_ferr_r <= 1'b0;
    end else if (ce) begin
      rx_end_r <= 1'b0;
      if (rx_state_r != RX_IDLE && rx_cnt_r != 8'h00) begin
        rx_cnt_r <= rx_cnt_r - 8'h01;
      end else begin
        unique case (rx_state_r)
          RX_IDLE: begin
            // (RULE_18) edge start or software start trigger
            if (active_r && rx_en && (start_src_r ? fall_edge : sw_start_r)) begin
              rx_state_r <= RX_START;
              rx_cnt_r <= half_m1;
              rx_shift_r <= '0;
              rx_perr_r <= 1'b0;
              rx_ferr_r <= 1'b0;
            end
          end
          RX_START: begin
            // mid start bit must still be low, else a glitch
            rx_state_r <= rx_f_r ? RX_IDLE : RX_DATA;
            rx_cnt_r <= period_m1;
            rx_idx_r <= '0;
          end
          RX_DATA: begin
            rx_shift_r[rx_pos] <= rx_f_r;
            rx_idx_r <= rx_idx_r + 4'h1;
            rx_cnt_r <= period_m1;
            if (rx_idx_r == len_bits - 4'h1) begin
              if (par_sel != PAR_NONE) begin
                rx_state_r <= RX_PARITY;
              end else if (stop_sel != STOP_NONE) begin
                rx_state_r <= RX_STOP;
                rx_stop2_r <= stop_sel != STOP_ONE;
              end else begin
                rx_state_r <= RX_IDLE;
                rx_end_r <= 1'b1;
              end
            end
          end
          RX_PARITY: begin
            // (RULE_16) even/odd checked, zero parity is not checked
            // (RULE_19) parity mismatch
            rx_perr_r <= (par_sel == PAR_EVEN && (^rx_shift_r ^ rx_f_r)) ||
                         (par_sel == PAR_ODD && !(^rx_shift_r ^ rx_f_r));
            rx_cnt_r <= period_m1;
            // (RULE_01) stop count chosen after the parity bit
            if (stop_sel != STOP_NONE) begin
              rx_state_r <= RX_STOP;
              rx_stop2_r <= stop_sel != STOP_ONE;
            end else begin
              rx_state_r <= RX_IDLE;
              rx_end_r <= 1'b1;
            end
          end
          RX_STOP: begin
            // (RULE_19) low stop bit is a framing error
            if (!rx_f_r) begin
              rx_ferr_r <= 1'b1;
            end
            rx_cnt_r <= period_m1;
            rx_stop2_r <= 1'b0;
            if (!rx_stop2_r) begin
              rx_state_r <= RX_IDLE;
              rx_end_r <= 1'b1;
            end
          end
          default: rx_state_r <= RX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // receive data and error flags; a setting event wins over a clear
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_r <= '0;
      rx_full_r <= 1'b0;
      fef_r <= 1'b0;
      pef_r <= 1'b0;
      ovf_r <= 1'b0;
    end else if (ce) begin
      if (rx_end_r) begin
        rx_data_r <= rx_shift_r;
        rx_full_r <= 1'b1;
      end else if (do_rd && avs_address == OFS_DATA_DIVIDER) begin
        rx_full_r <= 1'b0;
      end
      // (RULE_08) framing flag cleared by bit 2
      if (rx_end_r && rx_ferr_r) begin
        fef_r <= 1'b1;
      end else if (do_wr && avs_address == OFS_ERR_CLEAR && avs_writedata[CLR_FRAMING]) begin
        fef_r <= 1'b0;
      end
      // (RULE_09) parity flag cleared by bit 1
      if (rx_end_r && rx_perr_r) begin
        pef_r <= 1'b1;
      end else if (do_wr && avs_address == OFS_ERR_CLEAR && avs_writedata[CLR_PARITY]) begin
        pef_r <= 1'b0;
      end
      // (RULE_10) overrun flag cleared by bit 0
      // (RULE_19) new frame while previous still unread
      if (rx_end_r && rx_full_r) begin
        ovf_r <= 1'b1;
      end else if (do_wr && avs_address == OFS_ERR_CLEAR && avs_writedata[CLR_OVERRUN]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmitter: frame built whole, shifted out lsb first
  // ----------------------------------------------------------------
  always_comb begin
    tx_frame = '1;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(len_bits)) begin
        tx_frame[1 + i] = lsb_first ? avs_writedata[i] : avs_writedata[int'(len_bits) - 1 - i];
      end
    end
    // parity sits right after the data; zero parity sends a 0
    if (par_sel != PAR_NONE) begin
      tx_frame[len_bits + 4'h1] = (par_sel != PAR_ZERO) & ((par_sel == PAR_ODD) ^
                                  ^(avs_writedata[8:0] & ~(9'h1FF << len_bits)));
    end
    tx_count = 4'h1 + len_bits + {3'h0, par_sel != PAR_NONE} +
               ((stop_sel == STOP_NONE) ? 4'h0 : (stop_sel == STOP_ONE) ? 4'h1 : 4'h2);
  end

  // write of the data register starts a frame when idle, transmit is enabled and the channel is active
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_r <= '1;
      tx_left_r <= '0;
      tx_cnt_r <= '0;
      tx_busy_r <= 1'b0;
      tx_done_r <= 1'b0;
    end else if (ce) begin
      tx_done_r <= 1'b0;
      if (!tx_busy_r) begin
        if (do_wr && avs_address == OFS_DATA_DIVIDER && tx_en && active_r) begin
          tx_shift_r <= tx_frame;
          tx_left_r <= tx_count;
          tx_cnt_r <= period_m1;
          tx_busy_r <= 1'b1;
        end
      end else if (tx_cnt_r != 8'h00) begin
        tx_cnt_r <= tx_cnt_r - 8'h01;
      end else begin
        tx_shift_r <= {1'b1, tx_shift_r[FRAME_W-1:1]};
        tx_left_r <= tx_left_r - 4'h1;
        tx_cnt_r <= period_m1;
        if (tx_left_r == 4'h1) begin
          tx_busy_r <= 1'b0;
          tx_done_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky status, enable, per-source mask and priority
  // ----------------------------------------------------------------
  assign ev[IRQ_RX_DONE] = rx_end_r;
  assign ev[IRQ_RX_ERR] = rx_end_r & err_irq_en & (rx_ferr_r | rx_perr_r | rx_full_r);
  assign ev[IRQ_TX_DONE] = tx_done_r;

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_stat_r <= ev | (irq_stat_r &
                    ~((do_wr && avs_address == OFS_IRQ_CLEAR) ? avs_writedata[2:0] : 3'h0));
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  generate
    for (genvar k = 0; k < NUM_SRC; k++) begin : g_src
      // per-source request pulse and its priority level
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_req_r[k] <= 1'b0;
          irq_prio_r[2*k +: 2] <= 2'h3;
        end else if (ce) begin
          // (RULE_11) mask at 1 blocks the request
          irq_req_r[k] <= ev[k] & ~mask_r[SRC_POS[k]];
          // (RULE_12) level from bit1 and bit0 registers
          irq_prio_r[2*k +: 2] <= {prio1_r[SRC_POS[k]], prio0_r[SRC_POS[k]]};
        end
      end
    end
  endgenerate

  assign irq = irq_r;
  assign irq_req = irq_req_r;
  assign irq_prio = irq_prio_r;

  // ----------------------------------------------------------------
  // port pins: pin 0 carries the serial line through its latch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_o <= '0;
      port0_oe <= '0;
    end else if (ce) begin
      // (RULE_14) latch value drives the pin
      port0_o[7:1] <= latch_r[7:1];
      // (RULE_05) (RULE_06) engine bit only while enabled and sending
      port0_o[0] <= latch_r[0] &
                    ((oen_r[0] && tx_busy_r) ? tx_shift_r[0] : level_r[0]);
      // (RULE_13) direction 0 turns the output buffer on
      port0_oe <= ~dir_r;
    end
  end
endmodule : uchcfg_top

// >>> testbench/uchcfg_top_sva.sv
// port assertions for the serial channel configuration block
`timescale 1ns/1ps
module uchcfg_top_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [uchcfg_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [uchcfg_pkg::DATA_W-1:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [uchcfg_pkg::NUM_SRC-1:0] irq_req,
  input wire logic [2*uchcfg_pkg::NUM_SRC-1:0] irq_prio,
  input wire logic [7:0] port0_o,
  input wire logic [7:0] port0_oe
);
  import uchcfg_pkg::*;
  logic [7:0] msk_r, p0_r, p1_r, dir_r, lat_r;
  wire logic wr_ok = avs_write && !avs_waitrequest;
  wire logic [7:0] d = avs_writedata[7:0];
  // shadow registers load at the completing edge, like the real ones
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msk_r <= RST_MASK;
      p0_r <= RST_PRIO;
      p1_r <= RST_PRIO;
      dir_r <= RST_PORT_DIR;
      lat_r <= 8'h00;
    end else if (wr_ok) begin
      if (avs_address == OFS_IRQ_MASK) msk_r <= d;
      if (avs_address == OFS_PRIO_BIT0) p0_r <= d;
      if (avs_address == OFS_PRIO_BIT1) p1_r <= d;
      if (avs_address == OFS_PORT_DIR) dir_r <= d;
      if (avs_address == OFS_PORT_LATCH) lat_r <= d;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_wait_one:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("ack late");
  a_ack_once:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack held");
  a_no_stray_ack:
    assert property (!(avs_read || avs_write) |=> avs_waitrequest) else $error("stray ack");
  a_prio_low:
    assert property (p0_r == $past(p0_r) |->
      {irq_prio[4], irq_prio[2], irq_prio[0]} == {p0_r[3], p0_r[5], p0_r[4]}) else $error("prio0");
  a_prio_high:
    assert property (p1_r == $past(p1_r) |->
      {irq_prio[5], irq_prio[3], irq_prio[1]} == {p1_r[3], p1_r[5], p1_r[4]}) else $error("prio1");
  a_dir_drive:
    assert property (dir_r == $past(dir_r) |-> port0_oe == ~dir_r) else $error("direction");
  a_latch_pin:
    assert property (lat_r == $past(lat_r) |->
      port0_o[7:1] == lat_r[7:1] && (lat_r[0] || !port0_o[0])) else $error("latch");
  a_mask_block:
    assert property ((irq_req & {msk_r[3], msk_r[5], msk_r[4]}) == 3'h0) else $error("mask");
endmodule : uchcfg_top_sva
bind uchcfg_top uchcfg_top_sva uchcfg_top_sva_i (.core_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_waitrequest, .irq_req, .irq_prio, .port0_o, .port0_oe);

// >>> testbench/uchcfg_uart_peer.sv
// far-side serial device: sends frames to the receiver, captures transmitted ones
`timescale 1ns/1ps
module uchcfg_uart_peer #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  output logic rx_line,
  input wire logic tx_line
);
  initial rx_line = 1'b1;
  // stop level from caller, low forces a framing fault
  task automatic send(input logic [7:0] v, input logic stop_v);
    logic [9:0] f;
    f = {stop_v, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rx_line <= 1'b1;
    @(posedge clk);
  endtask : send
  // samples mid-bit, least significant bit first
  task automatic fetch(output logic [7:0] v);
    @(negedge tx_line);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      v[i] = tx_line;
    end
  endtask : fetch
endmodule : uchcfg_uart_peer

// >>> testbench/uchcfg_test.sv
// self-checking bench for the serial channel configuration block
`timescale 1ns/1ps
module uchcfg_test;
  import uchcfg_pkg::*;
  localparam logic [6:0] DIV = 7'h4D;
  localparam logic [7:0] RD_A [6] = '{OFS_IRQ_MASK, OFS_PRIO_BIT0, OFS_PRIO_BIT1,
    OFS_OUT_LEVEL, OFS_PORT_DIR, 8'hFC};
  localparam logic [7:0] RD_V [6] = '{8'h38, 8'h38, 8'h38, 8'h01, 8'hFF, 8'h00};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, irq, rx_line;
  logic [2:0] irq_req;
  logic [5:0] irq_prio;
  logic [7:0] port0_o, port0_oe, b, got;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #12.5 core_clk = ~core_clk;
  uchcfg_top uchcfg_top_i (.core_clk, .rst_n, .ce(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .irq_req, .irq_prio,
    .serial_rx_pin(rx_line), .port0_o, .port0_oe);
  uchcfg_uart_peer #(.BIT_CLKS(2 * DIV + 2)) uchcfg_uart_peer_i (.clk(core_clk),
    .rx_line, .tx_line(port0_o[0]));
  function automatic logic [5:0] prio_exp(input logic [7:0] p0, input logic [7:0] p1);
    return {p1[3], p0[3], p1[5], p0[5], p1[4], p0[4]};
  endfunction : prio_exp
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one bus access, held until the slave drops waitrequest
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= v;
    @(posedge core_clk iff avs_waitrequest === 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wrap_up;
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // hang guard, over twice the roughly 8300 cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h3B83));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, RD_A[i], 32'h0);
      check(rd, {24'h0, RD_V[i]});
    end
    check({port0_oe, 2'b0, irq_prio}, 16'h003F);
    // random priority and direction values
    repeat (6) begin
      b = 8'($urandom());
      bus(1'b1, OFS_PRIO_BIT0, {24'h0, b});
      bus(1'b1, OFS_PRIO_BIT1, {24'h0, ~b});
      bus(1'b1, OFS_PORT_DIR, {24'h0, b});
      bus(1'b0, OFS_PRIO_BIT1, 32'h0);
      check(rd, {24'h0, ~b});
      repeat (2) @(negedge core_clk);
      check(irq_prio, prio_exp(b, ~b));
      check(port0_oe, 8'(~b));
    end
    bus(1'b1, OFS_PORT_LATCH, 32'h1);
    bus(1'b1, OFS_PORT_DIR, 32'hFE);
    bus(1'b1, OFS_OUT_LEVEL, 32'h1);
    bus(1'b1, OFS_OUT_ENABLE, 32'h1);
    bus(1'b1, OFS_FILTER_EN, 32'h1);
    bus(1'b1, OFS_MODE, 32'h100);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h7);
    bus(1'b1, OFS_COMM_CONFIG, 32'hC493);
    bus(1'b1, OFS_DATA_DIVIDER, {16'h0, DIV, 9'h0});
    repeat (4) @(posedge core_clk);
    bus(1'b1, OFS_START, 32'h2);
    check(port0_o[0], 1'b1);
    b = 8'($urandom());
    uchcfg_uart_peer_i.send(b, 1'b1);
    repeat (40) @(posedge core_clk);
    bus(1'b0, OFS_DATA_DIVIDER, 32'h0);
    check(rd[15:0], {DIV, 1'b0, b});
    bus(1'b0, OFS_IRQ_STATUS, 32'h0);
    check({irq, rd[0]}, 2'b11);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h7);
    repeat (2) @(negedge core_clk);
    check(irq, 1'b0);
    // overrun then framing fault: a zero write keeps the flag
    for (int k = 0; k < 3; k += 2) begin
      bus(1'b0, OFS_DATA_DIVIDER, 32'h0);
      uchcfg_uart_peer_i.send(8'($urandom()), k == 0);
      if (k == 0) uchcfg_uart_peer_i.send(8'h55, 1'b1);
      repeat (40) @(posedge core_clk);
      bus(1'b1, OFS_ERR_CLEAR, 32'h7 ^ (32'h1 << k));
      bus(1'b0, OFS_CH_STATUS, 32'h0);
      check(rd[k], 1'b1);
      bus(1'b1, OFS_ERR_CLEAR, 32'h1 << k);
      bus(1'b0, OFS_CH_STATUS, 32'h0);
      check(rd[k], 1'b0);
    end
    b = 8'($urandom());
    fork
      uchcfg_uart_peer_i.fetch(got);
      bus(1'b1, OFS_DATA_DIVIDER, {16'h0, DIV, 1'b0, b});
    join
    check(got, b);
    repeat (400) @(posedge core_clk);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0);
    check(rd[2:1], 2'b11);
    wrap_up();
  end
endmodule : uchcfg_test
